// ---- logic/psv_defs.vh ----
`ifndef PSV_DEFS_VH
`define PSV_DEFS_VH

// Clock and link timing
`define PSV_SYS_CLK_NS 25
`define PSV_LINK_HALF_NS 100
`define PSV_LINK_HALF_CYC (`PSV_LINK_HALF_NS / `PSV_SYS_CLK_NS)

// Register byte offsets
`define PSV_REG_CTRL 8'h00
`define PSV_REG_IDLE 8'h04
`define PSV_REG_WAKE_EN 8'h08
`define PSV_REG_VID_CMD 8'h0C
`define PSV_REG_STATUS 8'h10
`define PSV_REG_IRQ_STAT 8'h14
`define PSV_REG_IRQ_CLR 8'h18
`define PSV_REG_IRQ_EN 8'h1C

// Control register fields
`define PSV_CTRL_SLEEP_ENABLE_BIT 0
`define PSV_CTRL_TYPE_LO 1
`define PSV_CTRL_TYPE_HI 3
`define PSV_CTRL_AUTO 4

// Sleep type codes
`define PSV_SLP_S3 3'h3
`define PSV_SLP_S4 3'h4
`define PSV_SLP_S5 3'h5

// Power states
`define PSV_ST_S0 3'h0
`define PSV_ST_CX 3'h1
`define PSV_ST_S3 3'h2
`define PSV_ST_S5 3'h3
`define PSV_ST_G3 3'h4

// Interrupt bits
`define PSV_IRQ_ALERT 0
`define PSV_IRQ_VID_DONE 1
`define PSV_IRQ_WAKE 2
`define PSV_IRQ_BREAK 3
`define PSV_IRQ_W 4

// Link frame
`define PSV_CMD_SETVID 4'h1
`define PSV_FRAME_BITS 5'h10

`endif

// ---- logic/psv_vreg_link.v ----
`timescale 1ns/1ps
`include "psv_defs.vh"

module psv_vreg_link #(
  parameter HALF = `PSV_LINK_HALF_CYC
)(
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Request side
  input wire start,
  input wire [3:0] slaveAddr,
  input wire [7:0] vidCode,
  output reg busy,
  output reg done,
  output reg ack,
  // Link side, data already synchronised
  input wire dataSync,
  output reg clkOe,
  output reg dataOe
);

  reg [7:0] divCnt_q;
  reg [15:0] shift_q;
  reg [4:0] bitCnt_q;
  wire tick;

  // Half-period enable for the link clock
  assign tick = busy && (divCnt_q == HALF - 1);

  always @(posedge sys_clk)
  begin
    if (!rstn || !busy || tick)
      divCnt_q <= 8'h00;
    else
      divCnt_q <= divCnt_q + 8'h01;
  end

  // Frame engine: clock runs only while a frame is out, data moves on low phase
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      busy <= 1'b0;
      done <= 1'b0;
      ack <= 1'b0;
      clkOe <= 1'b0;
      dataOe <= 1'b0;
      shift_q <= 16'h0000;
      bitCnt_q <= 5'h00;
    end
    else
    begin
      done <= 1'b0;
      if (!busy && start)
      begin
        busy <= 1'b1;
        clkOe <= 1'b1;
        shift_q <= {slaveAddr, `PSV_CMD_SETVID, vidCode};
        dataOe <= ~slaveAddr[3];
        bitCnt_q <= 5'h00;
      end
      else if (tick && clkOe)
      begin
        clkOe <= 1'b0;
        if (bitCnt_q == `PSV_FRAME_BITS)
          ack <= ~dataSync;
      end
      else if (tick)
      begin
        if (bitCnt_q == `PSV_FRAME_BITS)
        begin
          busy <= 1'b0;
          done <= 1'b1;
          dataOe <= 1'b0;
        end
        else
        begin
          clkOe <= 1'b1;
          bitCnt_q <= bitCnt_q + 5'h01;
          shift_q <= {shift_q[14:0], 1'b0};
          // Release data for the answer bit, else drive low for a zero
          dataOe <= (bitCnt_q == `PSV_FRAME_BITS - 5'h01) ? 1'b0 : ~shift_q[14];
        end
      end
    end
  end

endmodule

// ---- logic/psv_power_ctrl.v ----
// Notes on behaviour
// - Block is sole link master and makes the link clock itself.
// - Regulators share the link; each frame carries a four-bit slave address.
// - A low alert line from a regulator is caught as a status change.
// - Data line is open-drain and two-way; each end releases it when idle.
// - Link clock is open-drain and stops whenever no frame is pending.
// - A voltage change is one frame carrying the target voltage code.
// - Idle levels C0,C1,C2,C4,C6 supported; C3 and C5 become C4.
// - Suspend-to-RAM keeps memory refreshed and stops external clocks.
// - Suspend-to-disk is handled exactly like soft-off.
// - Waking from soft-off starts a full boot, no context restore.
// - From fully-on, monitor-wait or idle level read enters requested idle.
// - Sleep enable in fully-on enters the sleep named by sleep type.
// - Snoop, message interrupt or legacy interrupt ends any idle state.
// - Enabled alarm or other enabled wake event brings sleep back to on.
// - Expansion wake pin and management bus alert never wake the system.
// - Power return from mechanical-off reboots or stays soft-off by option.
//
// Local design decisions: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
`include "psv_defs.vh"

module psv_power_ctrl #(
  parameter WAKE_W = 4,
  parameter LINK_HALF = `PSV_LINK_HALF_CYC
)(
  // Clock and reset
  input wire sys_clk,
  input wire rstn,
  // Register port
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire regWr,
  input wire regRd,
  output wire [31:0] regRdData,
  // Processor side, same clock
  input wire mwaitReq,
  input wire [2:0] mwaitLevel,
  input wire snoopReq,
  input wire msiReq,
  input wire legacyIrq,
  // Platform event pins
  input wire rtcAlarm,
  input wire [WAKE_W-1:0] wakePins,
  input wire powerFail,
  input wire mechOff,
  input wire pwrBtnOverride,
  input wire powerReturn,
  input wire coinCellIn,
  // State outputs
  output wire [2:0] powerState,
  output wire [2:0] idleState,
  output wire extClkRun,
  output wire memSelfRefresh,
  output wire coreRailOn,
  output wire susRailOn,
  output wire fullBootReq,
  output wire irqOut,
  // Regulator link pins
  input wire vreg_alert_n,
  input wire vreg_serial_data_i,
  output wire vreg_serial_data_o,
  output wire vreg_serial_data_oe,
  output wire vreg_serial_clock_o,
  output wire vreg_serial_clock_oe
);

  localparam PIN_W = WAKE_W + 8;

  reg [PIN_W-1:0] syncA_q;
  reg [PIN_W-1:0] syncB_q;
  wire alertSync;
  wire dataSync;
  wire alarmSync;
  wire [WAKE_W-1:0] wakeSync;
  wire failSync;
  wire mechSync;
  wire overrideSync;
  wire returnSync;
  wire coinSync;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [2:0] cLevel_q;
  reg [2:0] cLevel_d;
  reg boot_d;
  reg wakeEvt_d;
  reg breakEvt_d;

  reg [2:0] sleepType_q;
  reg autoRestart_q;
  reg [2:0] idleLevel_q;
  reg [WAKE_W:0] wakeEn_q;
  reg [3:0] vidAddr_q;
  reg [7:0] vidCode_q;
  reg [`PSV_IRQ_W-1:0] irqStat_q;
  reg [`PSV_IRQ_W-1:0] irqEn_q;
  reg [`PSV_IRQ_W-1:0] irqSet;
  reg [31:0] rdData_q;
  reg linkStart_q;

  reg extClk_q;
  reg selfRef_q;
  reg coreOn_q;
  reg susOn_q;
  reg boot_q;
  reg irq_q;
  reg dataO_q;
  reg clkO_q;

  wire linkBusy;
  wire linkDone;
  wire linkAck;
  wire linkClkOe;
  wire linkDataOe;

  wire wrCtrl;
  wire wrIdle;
  wire rdIdle;
  wire idleGo;
  wire [2:0] idleReq;
  wire anyWake;
  wire anyBreak;

  // Idle level mapping, unsupported levels fold onto supported ones
  function [2:0] map_level;
    input [2:0] lvl;
    begin
      case (lvl)
        3'h3: map_level = 3'h4;
        3'h5: map_level = 3'h4;
        3'h7: map_level = 3'h6;
        default: map_level = lvl;
      endcase
    end
  endfunction

  // Two-flop synchroniser for every pin from outside the clock domain
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      // Alert and data lines idle high; a low reset value would fake an alert
      syncA_q <= {2'b11, {(PIN_W-2){1'b0}}};
      syncB_q <= {2'b11, {(PIN_W-2){1'b0}}};
    end
    else
    begin
      syncA_q <= {vreg_alert_n, vreg_serial_data_i, rtcAlarm, wakePins,
                  powerFail, mechOff, pwrBtnOverride, powerReturn, coinCellIn};
      syncB_q <= syncA_q;
    end
  end

  // Unpack synchronised pins
  assign alertSync = syncB_q[PIN_W-1];
  assign dataSync = syncB_q[PIN_W-2];
  assign alarmSync = syncB_q[PIN_W-3];
  assign wakeSync = syncB_q[WAKE_W+4:5];
  assign failSync = syncB_q[4];
  assign mechSync = syncB_q[3];
  assign overrideSync = syncB_q[2];
  assign returnSync = syncB_q[1];
  assign coinSync = syncB_q[0];

  // Register port decode
  assign wrCtrl = regWr && (regAddr == `PSV_REG_CTRL);
  assign wrIdle = regWr && (regAddr == `PSV_REG_IDLE);
  assign rdIdle = regRd && (regAddr == `PSV_REG_IDLE);

  // Idle request from monitor-wait or from reading the idle level
  assign idleGo = mwaitReq || rdIdle;
  assign idleReq = map_level(mwaitReq ? mwaitLevel : idleLevel_q);

  // Only enabled sources wake; expansion wake and bus alert have no path here
  assign anyWake = (alarmSync && wakeEn_q[0]) ||
                   (|(wakeSync & wakeEn_q[WAKE_W:1]));
  assign anyBreak = snoopReq || msiReq || legacyIrq;

  // Power state transitions
  always @*
  begin
    state_d = state_q;
    cLevel_d = cLevel_q;
    boot_d = 1'b0;
    wakeEvt_d = 1'b0;
    breakEvt_d = 1'b0;
    case (state_q)
      `PSV_ST_S0:
      begin
        if (mechSync)
          state_d = `PSV_ST_G3;
        else if (wrCtrl && regWrData[`PSV_CTRL_SLEEP_ENABLE_BIT])
        begin
          // Sleep type given in the same write takes effect
          case (regWrData[`PSV_CTRL_TYPE_HI:`PSV_CTRL_TYPE_LO])
            `PSV_SLP_S3: state_d = `PSV_ST_S3;
            `PSV_SLP_S4: state_d = `PSV_ST_S5;
            `PSV_SLP_S5: state_d = `PSV_ST_S5;
            default: state_d = `PSV_ST_S0;
          endcase
        end
        else if (idleGo && idleReq != 3'h0)
        begin
          state_d = `PSV_ST_CX;
          cLevel_d = idleReq;
        end
      end
      `PSV_ST_CX:
      begin
        if (anyBreak)
        begin
          state_d = `PSV_ST_S0;
          cLevel_d = 3'h0;
          breakEvt_d = 1'b1;
        end
      end
      `PSV_ST_S3:
      begin
        if (anyWake)
        begin
          state_d = `PSV_ST_S0;
          wakeEvt_d = 1'b1;
        end
      end
      `PSV_ST_S5:
      begin
        if (failSync)
          state_d = `PSV_ST_G3;
        else if (overrideSync || anyWake)
        begin
          state_d = `PSV_ST_S0;
          boot_d = 1'b1;
          wakeEvt_d = 1'b1;
        end
      end
      `PSV_ST_G3:
      begin
        // Wake sources are not looked at while in mechanical-off
        if (failSync || mechSync)
          state_d = `PSV_ST_G3;
        else if (returnSync)
        begin
          state_d = autoRestart_q ? `PSV_ST_S0 : `PSV_ST_S5;
          boot_d = autoRestart_q;
        end
        else if (coinSync)
          state_d = `PSV_ST_S5;
      end
      default:
        state_d = `PSV_ST_G3;
    endcase
  end

  // State registers and state-derived outputs
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      state_q <= `PSV_ST_G3;
      cLevel_q <= 3'h0;
      extClk_q <= 1'b0;
      selfRef_q <= 1'b0;
      coreOn_q <= 1'b0;
      susOn_q <= 1'b0;
      boot_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cLevel_q <= cLevel_d;
      extClk_q <= (state_d == `PSV_ST_S0) || (state_d == `PSV_ST_CX);
      selfRef_q <= (state_d == `PSV_ST_S3);
      coreOn_q <= (state_d == `PSV_ST_S0) || (state_d == `PSV_ST_CX);
      susOn_q <= (state_d == `PSV_ST_S0) || (state_d == `PSV_ST_CX) ||
                 (state_d == `PSV_ST_S3);
      boot_q <= boot_d;
    end
  end

  // Software control registers; wake enables survive power failure
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      sleepType_q <= 3'h0;
      autoRestart_q <= 1'b0;
      idleLevel_q <= 3'h0;
      wakeEn_q <= {(WAKE_W+1){1'b0}};
      irqEn_q <= {`PSV_IRQ_W{1'b0}};
    end
    else if (regWr)
    begin
      case (regAddr)
        `PSV_REG_CTRL:
        begin
          sleepType_q <= regWrData[`PSV_CTRL_TYPE_HI:`PSV_CTRL_TYPE_LO];
          autoRestart_q <= regWrData[`PSV_CTRL_AUTO];
        end
        `PSV_REG_IDLE: idleLevel_q <= regWrData[2:0];
        `PSV_REG_WAKE_EN: wakeEn_q <= regWrData[WAKE_W:0];
        `PSV_REG_IRQ_EN: irqEn_q <= regWrData[`PSV_IRQ_W-1:0];
        default: idleLevel_q <= idleLevel_q;
      endcase
    end
  end

  // Voltage command: a write while the link is busy is dropped
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      vidAddr_q <= 4'h0;
      vidCode_q <= 8'h00;
      linkStart_q <= 1'b0;
    end
    else
    begin
      linkStart_q <= 1'b0;
      if (regWr && regAddr == `PSV_REG_VID_CMD && !linkBusy && !linkStart_q)
      begin
        vidAddr_q <= regWrData[3:0];
        vidCode_q <= regWrData[11:4];
        linkStart_q <= 1'b1;
      end
    end
  end

  // Event collection for the sticky status
  always @*
  begin
    irqSet = {`PSV_IRQ_W{1'b0}};
    irqSet[`PSV_IRQ_ALERT] = ~alertSync;
    irqSet[`PSV_IRQ_VID_DONE] = linkDone;
    irqSet[`PSV_IRQ_WAKE] = wakeEvt_d;
    irqSet[`PSV_IRQ_BREAK] = breakEvt_d;
  end

  // Sticky status: a new event beats a clear in the same cycle
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      irqStat_q <= {`PSV_IRQ_W{1'b0}};
      irq_q <= 1'b0;
    end
    else
    begin
      if (regWr && regAddr == `PSV_REG_IRQ_CLR)
        irqStat_q <= (irqStat_q & ~regWrData[`PSV_IRQ_W-1:0]) | irqSet;
      else
        irqStat_q <= irqStat_q | irqSet;
      irq_q <= |((irqStat_q | irqSet) & irqEn_q);
    end
  end

  // Read data, valid in the cycle after the read strobe
  always @(posedge sys_clk)
  begin
    if (!rstn)
      rdData_q <= 32'h00000000;
    else if (regRd)
    begin
      case (regAddr)
        `PSV_REG_CTRL: rdData_q <= {27'h0, autoRestart_q, sleepType_q, 1'b0};
        `PSV_REG_IDLE: rdData_q <= {29'h0, idleLevel_q};
        `PSV_REG_WAKE_EN: rdData_q <= {{(31-WAKE_W){1'b0}}, wakeEn_q};
        `PSV_REG_VID_CMD: rdData_q <= {20'h0, vidCode_q, vidAddr_q};
        `PSV_REG_STATUS:
          rdData_q <= {24'h0, linkAck, linkBusy, cLevel_q, state_q};
        `PSV_REG_IRQ_STAT: rdData_q <= {28'h0, irqStat_q};
        `PSV_REG_IRQ_EN: rdData_q <= {28'h0, irqEn_q};
        default: rdData_q <= 32'h00000000;
      endcase
    end
    else
      rdData_q <= 32'h00000000;
  end

  // Open-drain pins only ever pull low
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      dataO_q <= 1'b0;
      clkO_q <= 1'b0;
    end
    else
    begin
      dataO_q <= 1'b0;
      clkO_q <= 1'b0;
    end
  end

  // Serial frame engine
  psv_vreg_link #(
    .HALF(LINK_HALF)
  ) u_link (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .start(linkStart_q),
    .slaveAddr(vidAddr_q),
    .vidCode(vidCode_q),
    .busy(linkBusy),
    .done(linkDone),
    .ack(linkAck),
    .dataSync(dataSync),
    .clkOe(linkClkOe),
    .dataOe(linkDataOe)
  );

  // Outputs
  assign regRdData = rdData_q;
  assign powerState = state_q;
  assign idleState = cLevel_q;
  assign extClkRun = extClk_q;
  assign memSelfRefresh = selfRef_q;
  assign coreRailOn = coreOn_q;
  assign susRailOn = susOn_q;
  assign fullBootReq = boot_q;
  assign irqOut = irq_q;
  assign vreg_serial_data_o = dataO_q;
  assign vreg_serial_data_oe = linkDataOe;
  assign vreg_serial_clock_o = clkO_q;
  assign vreg_serial_clock_oe = linkClkOe;

endmodule

// ---- bench/psv_vreg_model.sv ----
`timescale 1ns/1ps
`include "psv_defs.vh"
module psv_vreg_model #(
  parameter logic [3:0] MY_ADDR = 4'h5
)(
  // Board-level link lines
  input wire clkLine,
  input wire dataLine,
  // Bench control
  input wire raiseAlert,
  // Open-drain pulls and last accepted code
  output logic pullData = 1'b0,
  output logic alertN = 1'b1,
  output logic [7:0] lastCode = 8'h00
);
  logic [15:0] frame_q = 16'h0000;
  logic [4:0] cnt_q = 5'h00;

  // Bits are taken on the rising line, replies move on the falling line
  always @(posedge clkLine or negedge clkLine)
  begin
    if (clkLine)
    begin
      pullData <= 1'b0;
      frame_q <= {frame_q[14:0], dataLine};
      cnt_q <= (cnt_q == 5'h10) ? 5'h00 : cnt_q + 5'h01;
    end
    else
    begin
      alertN <= ~raiseAlert;
      if (cnt_q == 5'h10 && frame_q[15:12] == MY_ADDR && frame_q[11:8] == `PSV_CMD_SETVID)
      begin
        pullData <= 1'b1;
        lastCode <= frame_q[7:0];
      end
    end
  end
endmodule

// ---- bench/psv_power_chk.sv ----
`timescale 1ns/1ps
`include "psv_defs.vh"
module psv_power_chk #(
  parameter LINK_HALF = `PSV_LINK_HALF_CYC
)(
  // Clock and reset
  input logic sys_clk,
  input logic rstn,
  // Watched outputs
  input logic [2:0] powerState,
  input logic [2:0] idleState,
  input logic extClkRun,
  input logic memSelfRefresh,
  input logic coreRailOn,
  input logic susRailOn,
  input logic fullBootReq,
  input logic vreg_serial_data_oe,
  input logic vreg_serial_clock_oe
);
  logic prevOe_q;
  logic [7:0] run_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  // Length of the current link clock phase
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      prevOe_q <= 1'b0;
      run_q <= 8'h00;
    end
    else
    begin
      prevOe_q <= vreg_serial_clock_oe;
      run_q <= (vreg_serial_clock_oe != prevOe_q) ? 8'h01 : run_q + 8'h01;
    end
  end

  // A boot request is one cycle long and lands in fully-on
  sequence s_bootDone;
    ##[0:1] (powerState == `PSV_ST_S0) ##1 !fullBootReq;
  endsequence

  AST_CLK_LOW_PHASE: assert property (prevOe_q && !vreg_serial_clock_oe |-> run_q == LINK_HALF)
    else $error("link clock low phase length wrong");
  AST_DATA_ON_FALL: assert property ($changed(vreg_serial_data_oe) |-> $rose(vreg_serial_clock_oe))
    else $error("data moved off the falling clock");
  AST_S3_OUTS: assert property ($stable(powerState) && powerState == `PSV_ST_S3
    |-> memSelfRefresh && !extClkRun && !coreRailOn && susRailOn)
    else $error("suspend-to-ram outputs wrong");
  AST_OFF_OUTS: assert property ($stable(powerState) && powerState >= `PSV_ST_S5
    |-> !memSelfRefresh && !extClkRun && !coreRailOn && !susRailOn)
    else $error("off-state outputs wrong");
  AST_IDLE_LEVEL: assert property (idleState != 3'h3 && idleState != 3'h5 && idleState != 3'h7)
    else $error("unsupported idle level shown");
  AST_SLEEP_FROM_ON: assert property ($changed(powerState) && powerState == `PSV_ST_S3
    |-> $past(powerState) == `PSV_ST_S0)
    else $error("sleep entered from a state other than on");
  AST_IDLE_FROM_ON: assert property ($changed(powerState) && powerState == `PSV_ST_CX
    |-> $past(powerState) == `PSV_ST_S0)
    else $error("idle entered from a state other than on");
  AST_IDLE_EXIT: assert property ($changed(powerState) && $past(powerState) == `PSV_ST_CX
    |-> powerState == `PSV_ST_S0)
    else $error("idle left to a state other than on");
  AST_G3_EXIT: assert property ($changed(powerState) && $past(powerState) == `PSV_ST_G3
    |-> powerState == `PSV_ST_S0 || powerState == `PSV_ST_S5)
    else $error("mechanical-off left to a wrong state");
  AST_BOOT_PULSE: assert property (fullBootReq |-> s_bootDone)
    else $error("boot request not one cycle in on");
endmodule

bind psv_power_ctrl psv_power_chk #(.LINK_HALF(LINK_HALF)) chk_u (.sys_clk, .rstn,
  .powerState, .idleState, .extClkRun, .memSelfRefresh, .coreRailOn, .susRailOn,
  .fullBootReq, .vreg_serial_data_oe, .vreg_serial_clock_oe);

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`include "psv_defs.vh"
module tb_top;
  // Clock, reset and register port
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWrData = 32'h0;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  wire [31:0] regRdData;
  // Idle request, event pins and alert control
  logic mwaitReq = 1'b0;
  logic [2:0] mwaitLevel = 3'h0;
  logic [12:0] ev = 13'h0;
  logic raiseAlert = 1'b0;
  // Outputs and pulled-up link lines
  wire [2:0] powerState;
  wire [2:0] idleState;
  wire extClkRun, memSelfRefresh, coreRailOn, susRailOn, fullBootReq, irqOut;
  wire dOe, cOe, dO, cO, pullData, alertN;
  wire [7:0] lastCode;
  wire clkLine = (cOe !== 1'b1);
  wire dataLine = !(dOe === 1'b1 || pullData);
  int n_fail = 0;
  int n_compared = 0;
  int nBoot = 0;
  logic [31:0] rdv;

  always #12.5 sys_clk = ~sys_clk;

  // Count boot requests
  always @(posedge sys_clk)
    if (fullBootReq === 1'b1)
      nBoot <= nBoot + 1;

  psv_power_ctrl dut_u (.sys_clk, .rstn, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .mwaitReq, .mwaitLevel, .snoopReq(ev[6]), .msiReq(ev[7]), .legacyIrq(ev[8]),
    .rtcAlarm(ev[0]), .wakePins(ev[12:9]), .powerFail(ev[1]), .mechOff(ev[2]),
    .pwrBtnOverride(ev[3]), .powerReturn(ev[4]), .coinCellIn(ev[5]), .powerState,
    .idleState, .extClkRun, .memSelfRefresh, .coreRailOn, .susRailOn, .fullBootReq, .irqOut,
    .vreg_alert_n(alertN), .vreg_serial_data_i(dataLine), .vreg_serial_data_o(dO),
    .vreg_serial_data_oe(dOe), .vreg_serial_clock_o(cO), .vreg_serial_clock_oe(cOe));
  psv_vreg_model vr_u (.clkLine, .dataLine, .raiseAlert, .pullData, .alertN, .lastCode);

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      n_fail++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge sys_clk);
    regWr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge sys_clk);
    regRd <= 1'b0;
    #1;
    d = regRdData;
  endtask

  task automatic pulse(input int k);
    @(posedge sys_clk);
    ev[k] <= 1'b1;
    repeat (4) @(posedge sys_clk);
    ev[k] <= 1'b0;
  endtask

  task automatic waitSt(input logic [2:0] exp);
    int i;
    for (i = 0; i < 60 && powerState !== exp; i++)
      tick(1);
    cmp(powerState, exp, "state");
    if (powerState !== exp)
      finish_test;
  endtask

  task automatic frame(input logic [7:0] code, input logic [3:0] addr, input logic ackExp);
    int i;
    wr(`PSV_REG_IRQ_CLR, 32'h2);
    wr(`PSV_REG_VID_CMD, {20'h0, code, addr});
    for (i = 0; i < 400 && irqOut !== 1'b1; i++)
      tick(1);
    cmp(irqOut, 1'b1, "frame done");
    if (irqOut !== 1'b1)
      finish_test;
    rd(`PSV_REG_STATUS, rdv);
    cmp(rdv[7:6], {ackExp, 1'b0}, "ack");
    cmp({clkLine, dataLine}, 2'h3, "lines idle");
    cmp({dO, cO}, 2'h0, "open drain levels");
  endtask

  initial
  begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    tick(2);
    cmp({powerState, extClkRun, coreRailOn, susRailOn, irqOut, dOe, cOe}, {`PSV_ST_G3, 6'h0}, "rst");
    rd(`PSV_REG_STATUS, rdv);
    cmp(rdv, {29'h0, `PSV_ST_G3}, "status");
    rd(8'h40, rdv);
    cmp(rdv, 32'h0, "unmapped");
    // Mechanical-off ignores wakes; coin cell gives soft-off; alarm wakes with boot
    wr(`PSV_REG_WAKE_EN, 32'h1F);
    pulse(0);
    tick(6);
    cmp(powerState, `PSV_ST_G3, "g3 wake");
    pulse(5);
    waitSt(`PSV_ST_S5);
    wr(`PSV_REG_IRQ_EN, 32'h4);
    pulse(0);
    waitSt(`PSV_ST_S0);
    tick(3);
    cmp(nBoot, 1, "boot");
    cmp(irqOut, 1'b1, "irq");
    rd(`PSV_REG_IRQ_STAT, rdv);
    cmp(rdv, 32'h4, "irq stat");
    wr(`PSV_REG_IRQ_EN, 32'h0);
    tick(2);
    cmp(irqOut, 1'b0, "irq mask");
    wr(`PSV_REG_IRQ_EN, 32'h4);
    wr(`PSV_REG_IRQ_CLR, 32'h4);
    tick(2);
    cmp(irqOut, 1'b0, "irq clr");
    // Each idle level by register read, ended by rotating break events
    for (int l = 1; l < 8; l++)
    begin
      wr(`PSV_REG_IDLE, l);
      rd(`PSV_REG_IDLE, rdv);
      waitSt(`PSV_ST_CX);
      cmp(idleState, (l == 3 || l == 5) ? 4 : (l == 7 ? 6 : l), "level");
      pulse(6 + l % 3);
      waitSt(`PSV_ST_S0);
    end
    @(posedge sys_clk);
    mwaitLevel <= 3'h5;
    mwaitReq <= 1'b1;
    @(posedge sys_clk);
    mwaitReq <= 1'b0;
    waitSt(`PSV_ST_CX);
    cmp(idleState, 3'h4, "mwait");
    pulse(8);
    waitSt(`PSV_ST_S0);
    // Sleep types, disabled and enabled wake pins, and the off transitions
    wr(`PSV_REG_CTRL, 32'h5);
    tick(6);
    cmp(powerState, `PSV_ST_S0, "bad type");
    wr(`PSV_REG_WAKE_EN, 32'h1);
    wr(`PSV_REG_CTRL, 32'h7);
    waitSt(`PSV_ST_S3);
    tick(1);
    cmp({memSelfRefresh, extClkRun, coreRailOn, susRailOn}, 4'h9, "s3 outs");
    pulse(9);
    tick(6);
    cmp(powerState, `PSV_ST_S3, "masked wake");
    wr(`PSV_REG_WAKE_EN, 32'h3);
    pulse(9);
    waitSt(`PSV_ST_S0);
    tick(2);
    cmp(nBoot, 1, "s3 resume");
    wr(`PSV_REG_CTRL, 32'h9);
    waitSt(`PSV_ST_S5);
    tick(1);
    cmp({memSelfRefresh, coreRailOn, susRailOn}, 3'h0, "s4 outs");
    pulse(3);
    waitSt(`PSV_ST_S0);
    pulse(2);
    waitSt(`PSV_ST_G3);
    pulse(4);
    waitSt(`PSV_ST_S5);
    pulse(3);
    waitSt(`PSV_ST_S0);
    wr(`PSV_REG_CTRL, 32'hB);
    waitSt(`PSV_ST_S5);
    pulse(1);
    waitSt(`PSV_ST_G3);
    wr(`PSV_REG_CTRL, 32'h10);
    pulse(4);
    waitSt(`PSV_ST_S0);
    // Voltage frames: answered, foreign address, alert, and one dropped while busy
    wr(`PSV_REG_IRQ_EN, 32'h2);
    @(posedge sys_clk);
    raiseAlert <= 1'b1;
    frame(8'hA5, 4'h5, 1'b1);
    cmp(lastCode, 8'hA5, "code");
    rd(`PSV_REG_IRQ_STAT, rdv);
    cmp(rdv[0], 1'b1, "alert");
    @(posedge sys_clk);
    raiseAlert <= 1'b0;
    frame(8'h5A, 4'h6, 1'b0);
    cmp(lastCode, 8'hA5, "foreign");
    wr(`PSV_REG_IRQ_CLR, 32'h1);
    rd(`PSV_REG_IRQ_STAT, rdv);
    cmp(rdv[0], 1'b0, "alert clr");
    wr(`PSV_REG_VID_CMD, 32'h3C5);
    frame(8'hC3, 4'h5, 1'b1);
    cmp(lastCode, 8'h3C, "busy drop");
    finish_test;
  end
endmodule
